// *** remap_input_pkg.sv ***
package remap_input_pkg;

    // ======================================================================
    // Widths
    // ======================================================================
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SEL_W = 7;
    localparam int unsigned PIN_COUNT = 125;

    // ======================================================================
    // Register offsets
    // ======================================================================
    localparam logic [ADDR_W-1:0] OFS_EXT_IRQ1 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_A = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_B = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CAN_PAIR = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_D = 4'h8;

    // ======================================================================
    // Field positions and reset values
    // ======================================================================
    localparam int unsigned LOW_FIELD_LSB = 0;
    localparam int unsigned HIGH_FIELD_LSB = 8;
    localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;

    // ======================================================================
    // Selector codes
    // ======================================================================
    localparam logic [SEL_W-1:0] CODE_VSS = 7'h00;
    localparam logic [SEL_W-1:0] CODE_CMP = 7'h01;
    localparam logic [SEL_W-1:0] CODE_FIRST_PIN = 7'h02;
    localparam logic [SEL_W-1:0] CODE_PIN124_STD = 7'h7C;
    localparam logic [SEL_W-1:0] CODE_PIN124_EXT = 7'h7F;
    localparam logic [SEL_W-1:0] PIN_TOP_INDEX = 7'h7C;

    typedef enum logic {
        CODE_MAP_STANDARD,
        CODE_MAP_EXTENDED
    } codeMap_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } regReq_t;

    typedef struct packed {
        logic extIrq1Input;
        logic serialARxInput;
        logic serialBRxInput;
        logic canARxInput;
        logic canBRxInput;
        logic serialDCtsInput;
        logic serialDRxInput;
    } peripheralIn_t;

    // ======================================================================
    // Code-to-source decode
    // ======================================================================
    // Codes outside the pin table fall back to a constant low.
    function automatic logic pickSource(
        input logic [SEL_W-1:0] sel,
        input logic [PIN_COUNT-1:0] pins,
        input logic cmp,
        input codeMap_t map
    );
        logic pinOk;
        logic [SEL_W-1:0] idx;
        pinOk = 1'b0;
        idx = sel;
        if (map == CODE_MAP_STANDARD) begin
            pinOk = (sel >= CODE_FIRST_PIN) && (sel <= CODE_PIN124_STD);
        end else if (sel == CODE_PIN124_EXT) begin
            pinOk = 1'b1;
            idx = PIN_TOP_INDEX;
        end else begin
            pinOk = (sel >= CODE_FIRST_PIN) && (sel < CODE_PIN124_STD);
        end
        if (sel == CODE_VSS) begin
            pickSource = 1'b0;
        end else if (sel == CODE_CMP) begin
            pickSource = cmp;
        end else if (pinOk) begin
            pickSource = pins[idx];
        end else begin
            pickSource = 1'b0;
        end
    endfunction : pickSource

endpackage : remap_input_pkg

// *** selector_reg.sv ***
module selector_reg
    import remap_input_pkg::*;
#(
    parameter bit LOW_EN = 1'b1,
    parameter bit HIGH_EN = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] value,
    output logic [SEL_W-1:0] lowSel,
    output logic [SEL_W-1:0] highSel
);

    // ======================================================================
    // Selector fields
    // ======================================================================
    logic [SEL_W-1:0] lowSel_q;
    logic [SEL_W-1:0] lowSel_d;
    logic [SEL_W-1:0] highSel_q;
    logic [SEL_W-1:0] highSel_d;

    // A disabled field never loads, so it stays at its reset code.
    assign lowSel_d = (wrEn && LOW_EN) ? wdata[LOW_FIELD_LSB +: SEL_W] : lowSel_q;
    assign highSel_d = (wrEn && HIGH_EN) ? wdata[HIGH_FIELD_LSB +: SEL_W] : highSel_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowSel_q <= SEL_RESET;
            highSel_q <= SEL_RESET;
        end else begin
            lowSel_q <= lowSel_d;
            highSel_q <= highSel_d;
        end
    end

    assign lowSel = lowSel_q;
    assign highSel = highSel_q;
    assign value = {1'b0, highSel_q, 1'b0, lowSel_q};

endmodule : selector_reg

// *** input_source_mux.sv ***
module input_source_mux
    import remap_input_pkg::*;
#(
    parameter codeMap_t CODE_MAP = CODE_MAP_STANDARD
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SEL_W-1:0] sel,
    input wire logic [PIN_COUNT-1:0] pinSync,
    input wire logic cmpSync,
    output logic routed
);

    // ======================================================================
    // Routed input
    // ======================================================================
    logic routed_q;
    logic routed_d;

    // Registered so the peripheral never sees a glitch while the code changes.
    assign routed_d = pickSource(sel, pinSync, cmpSync, CODE_MAP);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            routed_q <= 1'b0;
        end else begin
            routed_q <= routed_d;
        end
    end

    assign routed = routed_q;

endmodule : input_source_mux

// *** remappable_input_select.sv ***
module remappable_input_select
    import remap_input_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire regReq_t regReq,
    output logic [DATA_W-1:0] rdData,
    input wire logic [PIN_COUNT-1:0] padIn,
    input wire logic comparatorAOutput,
    output peripheralIn_t periphIn
);

    // ======================================================================
    // Pad and comparator synchronisers
    // ======================================================================
    // Pads and the comparator are asynchronous to clk, so two stages each.
    logic [PIN_COUNT-1:0] padMeta_q;
    logic [PIN_COUNT-1:0] padSync_q;
    logic cmpMeta_q;
    logic cmpSync_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            padMeta_q <= '0;
            padSync_q <= '0;
        end else begin
            padMeta_q <= padIn;
            padSync_q <= padMeta_q;
        end
    end

    // The comparator has its own pair, so it can be placed apart from the pad bus.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmpMeta_q <= 1'b0;
            cmpSync_q <= 1'b0;
        end else begin
            cmpMeta_q <= comparatorAOutput;
            cmpSync_q <= cmpMeta_q;
        end
    end

    // ======================================================================
    // Address decode
    // ======================================================================
    // Whole-word compares, so an odd or unlisted offset matches nothing and reads zero.
    function automatic logic addrHit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        addrHit = (addr == ofs);
    endfunction : addrHit

    wire hitExtIrq1 = addrHit(regReq.addr, OFS_EXT_IRQ1);
    wire hitSerialA = addrHit(regReq.addr, OFS_SERIAL_A);
    wire hitSerialB = addrHit(regReq.addr, OFS_SERIAL_B);
    wire hitCanPair = addrHit(regReq.addr, OFS_CAN_PAIR) && HAS_CAN;
    wire hitSerialD = addrHit(regReq.addr, OFS_SERIAL_D);

    // A write to an unmapped offset raises no enable, so it is simply lost.
    wire wrExtIrq1 = regReq.wr && hitExtIrq1;
    wire wrSerialA = regReq.wr && hitSerialA;
    wire wrSerialB = regReq.wr && hitSerialB;
    wire wrCanPair = regReq.wr && hitCanPair;
    wire wrSerialD = regReq.wr && hitSerialD;

    // ======================================================================
    // Selector registers
    // ======================================================================
    logic [DATA_W-1:0] valExtIrq1;
    logic [DATA_W-1:0] valSerialA;
    logic [DATA_W-1:0] valSerialB;
    logic [DATA_W-1:0] valCanPair;
    logic [DATA_W-1:0] valSerialD;
    logic [SEL_W-1:0] extIrq1SourceSel;
    logic [SEL_W-1:0] serialARxSourceSel;
    logic [SEL_W-1:0] serialBRxSourceSel;
    logic [SEL_W-1:0] canARxSourceSel;
    logic [SEL_W-1:0] canBRxSourceSel;
    logic [SEL_W-1:0] serialDCtsSourceSel;
    logic [SEL_W-1:0] serialDRxSourceSel;

    // Every field clears on reset, so each routed input starts from a constant low.
    selector_reg #(
        .LOW_EN(1'b0),
        .HIGH_EN(1'b1)
    ) uRegExtIrq1 (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(wrExtIrq1),
        .wdata(regReq.wdata),
        .value(valExtIrq1),
        .lowSel(),
        .highSel(extIrq1SourceSel)
    );

    selector_reg #(
        .LOW_EN(1'b1),
        .HIGH_EN(1'b0)
    ) uRegSerialA (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(wrSerialA),
        .wdata(regReq.wdata),
        .value(valSerialA),
        .lowSel(serialARxSourceSel),
        .highSel()
    );

    selector_reg #(
        .LOW_EN(1'b1),
        .HIGH_EN(1'b0)
    ) uRegSerialB (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(wrSerialB),
        .wdata(regReq.wdata),
        .value(valSerialB),
        .lowSel(serialBRxSourceSel),
        .highSel()
    );

    // Without CAN the register is left out, so its offset reads zero and both receivers stay low.
    if (HAS_CAN) begin : canPairPresent
        selector_reg #(
            .LOW_EN(1'b1),
            .HIGH_EN(1'b1)
        ) uRegCanPair (
            .clk(clk),
            .rst_b(rst_b),
            .wrEn(wrCanPair),
            .wdata(regReq.wdata),
            .value(valCanPair),
            .lowSel(canARxSourceSel),
            .highSel(canBRxSourceSel)
        );
    end else begin : canPairAbsent
        assign valCanPair = 16'h0000;
        assign canARxSourceSel = SEL_RESET;
        assign canBRxSourceSel = SEL_RESET;
    end

    selector_reg #(
        .LOW_EN(1'b1),
        .HIGH_EN(1'b1)
    ) uRegSerialD (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(wrSerialD),
        .wdata(regReq.wdata),
        .value(valSerialD),
        .lowSel(serialDRxSourceSel),
        .highSel(serialDCtsSourceSel)
    );

    // ======================================================================
    // Read path
    // ======================================================================
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    // Hits are mutually exclusive, so the order of this chain costs only depth.
    wire [DATA_W-1:0] readMux =
        hitExtIrq1 ? valExtIrq1 :
        hitSerialA ? valSerialA :
        hitSerialB ? valSerialB :
        hitCanPair ? valCanPair :
        hitSerialD ? valSerialD : 16'h0000;

    // Data stand only in the cycle after the read strobe.
    assign rdData_d = regReq.rd ? readMux : 16'h0000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign rdData = rdData_q;

    // ======================================================================
    // Source multiplexers
    // ======================================================================
    // All multiplexers share one synchronised pad bus, so no pad pays for a second pair of stages.
    logic routedExtIrq1;
    logic routedSerialARx;
    logic routedSerialBRx;
    logic routedCanARx;
    logic routedCanBRx;
    logic routedSerialDCts;
    logic routedSerialDRx;

    input_source_mux #(
        .CODE_MAP(CODE_MAP_STANDARD)
    ) uMuxExtIrq1 (
        .clk(clk),
        .rst_b(rst_b),
        .sel(extIrq1SourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedExtIrq1)
    );

    input_source_mux #(
        .CODE_MAP(CODE_MAP_STANDARD)
    ) uMuxSerialA (
        .clk(clk),
        .rst_b(rst_b),
        .sel(serialARxSourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedSerialARx)
    );

    input_source_mux #(
        .CODE_MAP(CODE_MAP_STANDARD)
    ) uMuxSerialB (
        .clk(clk),
        .rst_b(rst_b),
        .sel(serialBRxSourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedSerialBRx)
    );

    input_source_mux #(
        .CODE_MAP(CODE_MAP_STANDARD)
    ) uMuxCanA (
        .clk(clk),
        .rst_b(rst_b),
        .sel(canARxSourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedCanARx)
    );

    input_source_mux #(
        .CODE_MAP(CODE_MAP_STANDARD)
    ) uMuxCanB (
        .clk(clk),
        .rst_b(rst_b),
        .sel(canBRxSourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedCanBRx)
    );

    input_source_mux #(
        .CODE_MAP(CODE_MAP_EXTENDED)
    ) uMuxSerialDCts (
        .clk(clk),
        .rst_b(rst_b),
        .sel(serialDCtsSourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedSerialDCts)
    );

    input_source_mux #(
        .CODE_MAP(CODE_MAP_EXTENDED)
    ) uMuxSerialDRx (
        .clk(clk),
        .rst_b(rst_b),
        .sel(serialDRxSourceSel),
        .pinSync(padSync_q),
        .cmpSync(cmpSync_q),
        .routed(routedSerialDRx)
    );

    // ======================================================================
    // Peripheral inputs
    // ======================================================================
    // One driver for the whole carrier, first struct member in the top bit.
    assign periphIn = {
        routedExtIrq1,
        routedSerialARx,
        routedSerialBRx,
        routedCanARx,
        routedCanBRx,
        routedSerialDCts,
        routedSerialDRx
    };

endmodule : remappable_input_select

// *** remap_input_monitor.sv ***
module remap_input_monitor
    import remap_input_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire regReq_t regReq,
    input wire logic [DATA_W-1:0] rdData,
    input wire logic [PIN_COUNT-1:0] padIn,
    input wire logic comparatorAOutput,
    input wire peripheralIn_t periphIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of the interrupt selector, so source checks need no view inside the design.
    logic [SEL_W-1:0] irqSel_q;
    wire mapped = (regReq.addr[0] == 1'b0) && (regReq.addr <= OFS_SERIAL_D)
        && (HAS_CAN || regReq.addr != OFS_CAN_PAIR);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqSel_q <= SEL_RESET;
        end else if (regReq.wr && regReq.addr == OFS_EXT_IRQ1) begin
            irqSel_q <= regReq.wdata[14:8];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RD_IDLE: assert property (!$past(regReq.rd) |-> rdData == 16'h0000)
        else $error("read data outside its slot");
    AST_RD_RSVD: assert property (rdData[15] == 1'b0 && rdData[7] == 1'b0)
        else $error("reserved bit read as one");
    AST_UNMAPPED: assert property ($past(regReq.rd) && !$past(mapped) |-> rdData == 16'h0000)
        else $error("unmapped read not zero");
    AST_IRQ_LOW: assert property ($past(regReq.rd) && $past(regReq.addr) == OFS_EXT_IRQ1 |-> rdData[7:0] == 8'h00)
        else $error("interrupt register low byte not zero");
    AST_SERA_HIGH: assert property ($past(regReq.rd) && $past(regReq.addr) == OFS_SERIAL_A |-> rdData[15:8] == 8'h00)
        else $error("serial A register high byte not zero");
    AST_SERB_HIGH: assert property ($past(regReq.rd) && $past(regReq.addr) == OFS_SERIAL_B |-> rdData[15:8] == 8'h00)
        else $error("serial B register high byte not zero");
    AST_RST_CLEAR: assert property ($rose(rst_b) |-> (periphIn == 7'h00) [*3])
        else $error("routed input high after reset");
    AST_IRQ_VSS: assert property ((irqSel_q == 7'h00) [*3] |-> !periphIn.extIrq1Input)
        else $error("code zero not low");
    AST_IRQ_CMP: assert property (($stable(comparatorAOutput) && irqSel_q == 7'h01) [*4]
        |-> periphIn.extIrq1Input == comparatorAOutput)
        else $error("code one not comparator");
    AST_IRQ_PIN124: assert property (($stable(padIn[124]) && irqSel_q == 7'h7C) [*4]
        |-> periphIn.extIrq1Input == padIn[124])
        else $error("top code not pin 124");
endmodule : remap_input_monitor

bind remappable_input_select remap_input_monitor #(.HAS_CAN(HAS_CAN)) u_monitor (.clk(clk), .rst_b(rst_b),
    .regReq(regReq), .rdData(rdData), .padIn(padIn), .comparatorAOutput(comparatorAOutput), .periphIn(periphIn));

// *** pad_source_model.sv ***
module pad_source_model
    import remap_input_pkg::*;
(
    input wire logic clk,
    input wire logic load,
    input wire logic [PIN_COUNT-1:0] pattern,
    input wire logic cmpLevel,
    output logic [PIN_COUNT-1:0] padIn,
    output logic comparatorAOutput
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pads move only on load, so a level can be judged once the synchroniser has settled.
    initial begin
        padIn = '0;
        comparatorAOutput = 1'b0;
    end
    always @(posedge clk) begin
        if (load) begin
            padIn <= pattern;
            comparatorAOutput <= cmpLevel;
        end
    end
endmodule : pad_source_model

// *** remappable_input_select_tb_top.sv ***
module remappable_input_select_tb_top
    import remap_input_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_b;
    regReq_t regReq;
    logic [DATA_W-1:0] rdData;
    logic [PIN_COUNT-1:0] padIn;
    logic comparatorAOutput;
    peripheralIn_t periphIn;
    logic [DATA_W-1:0] rdDataNoCan;
    peripheralIn_t periphInNoCan;
    logic load;
    logic [PIN_COUNT-1:0] pattern;
    logic cmpLevel;
    int errors;
    int comparisons;
    int cycles;
    int regs[5];
    int codes[8] = '{0, 1, 2, 123, 124, 125, 126, 127};
    logic [15:0] mask[5] = '{16'h7F00, 16'h007F, 16'h007F, 16'h7F7F, 16'h7F7F};

    remappable_input_select #(.HAS_CAN(1'b1)) u_dut (.clk(clk), .rst_b(rst_b), .regReq(regReq), .rdData(rdData),
        .padIn(padIn), .comparatorAOutput(comparatorAOutput), .periphIn(periphIn));
    remappable_input_select #(.HAS_CAN(1'b0)) u_dut_no_can (.clk(clk), .rst_b(rst_b), .regReq(regReq),
        .rdData(rdDataNoCan), .padIn(padIn), .comparatorAOutput(comparatorAOutput), .periphIn(periphInNoCan));
    pad_source_model u_pads (.clk(clk), .load(load), .pattern(pattern), .cmpLevel(cmpLevel), .padIn(padIn),
        .comparatorAOutput(comparatorAOutput));

    // ==========================================================
    // Reference model and bus tasks
    // ==========================================================
    function automatic logic src(input int c, input bit ext);
        if (c == 1) return comparatorAOutput;
        if (ext && c == 127) return padIn[124];
        if (c >= 2 && c <= (ext ? 123 : 124)) return padIn[c];
        return 1'b0;
    endfunction : src

    function automatic logic [6:0] expPeriph();
        return {src(regs[0] >> 8, 0), src(regs[1], 0), src(regs[2], 0), src(regs[3] & 127, 0),
            src(regs[3] >> 8, 0), src(regs[4] >> 8, 1), src(regs[4] & 127, 1)};
    endfunction : expPeriph

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq.addr <= a;
        regReq.wdata <= d;
        regReq.wr <= 1'b1;
        @(posedge clk);
        regReq.wr <= 1'b0;
        if (a[0] == 1'b0 && a <= 4'h8) regs[a >> 1] = int'(d & mask[a >> 1]);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        @(posedge clk);
        regReq.rd <= 1'b0;
        #1;
        check("rdData", (a[0] == 1'b0 && a <= 4'h8) ? 16'(regs[a >> 1]) : 16'h0000, rdData);
        check("rdDataNoCan",
            (a[0] == 1'b0 && a <= 4'h8 && a != 4'h6) ? 16'(regs[a >> 1]) : 16'h0000, rdDataNoCan);
    endtask : rd

    task automatic settle();
        @(posedge clk);
        pattern <= PIN_COUNT'({$urandom, $urandom, $urandom, $urandom});
        cmpLevel <= 1'($urandom);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("periphIn", 16'(expPeriph()), 16'(periphIn));
        check("periphInNoCan", 16'(expPeriph() & 7'h73), 16'(periphInNoCan));
    endtask : settle

    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Clock, watchdog and main sequence
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 5000) begin
                errors++;
                give_verdict();
            end
        end
    end

    initial begin
        logic [15:0] w;
        rst_b = 1'b0;
        regReq = '0;
        load = 1'b0;
        pattern = '0;
        cmpLevel = 1'b0;
        errors = 0;
        comparisons = 0;
        void'($urandom(53373));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 10; a += 2) rd(4'(a));
        settle();
        // Boundary codes first, then random ones; junk in the unused bits every time.
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 5; i++) begin
                w = 16'($urandom);
                w[14:8] = 7'(k < 8 ? codes[(k + 2 * i + 3) % 8] : $urandom_range(127));
                w[6:0] = 7'(k < 8 ? codes[(k + i) % 8] : $urandom_range(127));
                wr(4'(2 * i), w);
                rd(4'(2 * i));
            end
            repeat (2) settle();
        end
        for (int a = 0; a < 16; a++) if (a % 2 == 1 || a > 8) wr(4'(a), 16'hFFFF);
        for (int a = 0; a < 16; a++) rd(4'(a));
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        regs = '{default: 0};
        for (int a = 0; a < 10; a += 2) rd(4'(a));
        settle();
        give_verdict();
    end
endmodule : remappable_input_select_tb_top
